// File: rtl/tlic_top.sv
// Two-level interrupt controller with APB register access
`timescale 1ns/1ps

module tlic_top
    import tlic_pkg::*;
#(
    parameter int NUSB = 8
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            timer_zero_overflow_event,
    input  wire logic            external_pin_zero_event,
    input  wire logic            port_change_event,
    input  wire logic [7:0]      periph_event,
    input  wire logic [NUSB-1:0] usb_event,
    input  wire logic            return_from_interrupt_instr,
    output logic                 stack_push,
    output logic                 pc_load,
    output logic      [20:0]     vector_addr,
    output logic                 service_high,
    output logic                 service_low
);

    localparam int NCORE = 3;
    localparam int NSRC  = NCORE + 9;

    // ========================================================
    // State
    typedef struct packed {
        logic [7:0]      ictl;
        logic            pen;
        logic [7:0]      pf1;
        logic [7:0]      pe1;
        logic [7:0]      pp1;
        logic            usb_en;
        logic            usb_pri;
        logic [2:0]      cpri;
        logic [NUSB-1:0] usbf;
        logic [NUSB-1:0] usbe;
        tlic_state_t     state;
        logic [1:0]      div;
        logic [1:0]      icnt;
        logic            vec_hi;
        logic            svc_hi;
        logic            svc_lo;
        logic            push;
        logic            load;
        logic [20:0]     vaddr;
        logic            rdy;
        logic            err;
        logic [31:0]     rdata;
    } tlic_regs_t;

    tlic_regs_t s;
    tlic_regs_t next_s;

    logic            usb_device_level_flag;
    logic [NSRC-1:0] flg;
    logic [NSRC-1:0] ena;
    logic [NSRC-1:0] pri;
    logic [NSRC-1:0] act;
    logic [NSRC-1:0] hi_act;
    logic [NSRC-1:0] lo_act;
    logic [NSRC-1:0] cmp_act;
    logic            req_hi;
    logic            req_lo;
    logic            tick;
    logic            apb_wr;
    logic            setup;
    logic            hit;
    logic [7:0]      rd8;

    // ========================================================
    // Source matrix
    assign usb_device_level_flag = |(s.usbf & s.usbe);
    assign flg = {usb_device_level_flag, s.pf1, s.ictl[2:0]};
    assign ena = {s.usb_en, s.pe1, s.ictl[5:3]};
    assign pri = {s.usb_pri, s.pp1, s.cpri};

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            assign act[gi]    = flg[gi] & ena[gi];
            assign hi_act[gi] = act[gi] & pri[gi];
            assign lo_act[gi] = act[gi] & ~pri[gi];
            // Core sources ignore the peripheral group enable
            if (gi < NCORE) begin : g_core
                assign cmp_act[gi] = act[gi];
            end else begin : g_per
                assign cmp_act[gi] = act[gi] & s.ictl[BIT_GLOW];
            end
        end
    endgenerate

    // Low level also needs the high enable, so a high routine blocks it
    always_comb begin
        if (s.pen) begin
            req_hi = s.ictl[BIT_GHIGH] & (|hi_act);
            req_lo = s.ictl[BIT_GLOW] & s.ictl[BIT_GHIGH] & (|lo_act)
                     & ~s.svc_hi & ~s.svc_lo;
        end else begin
            req_hi = s.ictl[BIT_GHIGH] & (|cmp_act);
            req_lo = 1'b0;
        end
    end

    assign tick   = (s.div == 2'(CYC_PER_INSTR - 1));
    assign setup  = psel & ~penable;
    assign apb_wr = psel & penable & s.rdy & pwrite;

    // ========================================================
    // Read mux
    always_comb begin
        hit = 1'b1;
        rd8 = 8'h00;
        case (paddr)
            OFS_ICTL: rd8 = s.ictl;
            OFS_RCS:  rd8 = {s.pen, 7'h00};
            OFS_PF1:  rd8 = s.pf1;
            OFS_PE1:  rd8 = s.pe1;
            OFS_PP1:  rd8 = s.pp1;
            OFS_PF2:  rd8 = {2'b00, usb_device_level_flag, 5'h00};
            OFS_PE2:  rd8 = {2'b00, s.usb_en, 5'h00};
            OFS_PP2:  rd8 = {2'b00, s.usb_pri, 5'h00};
            OFS_CPRI: rd8 = {5'h00, s.cpri};
            OFS_USBF: rd8 = 8'(s.usbf);
            OFS_USBE: rd8 = 8'(s.usbe);
            default:  hit = 1'b0;
        endcase
    end

    // ========================================================
    // Next state
    always_comb begin
        next_s      = s;
        next_s.push = 1'b0;
        next_s.load = 1'b0;
        next_s.div  = tick ? 2'd0 : s.div + 2'd1;

        // APB: answer one cycle after setup
        next_s.rdy = setup;
        if (setup) begin
            next_s.err   = ~hit;
            next_s.rdata = {24'h00_0000, rd8};
        end else if (s.rdy) begin
            next_s.err   = 1'b0;
            next_s.rdata = 32'h0000_0000;
        end

        if (apb_wr) begin
            case (paddr)
                OFS_ICTL: next_s.ictl    = pwdata[7:0];
                OFS_RCS:  next_s.pen     = pwdata[BIT_PEN];
                OFS_PF1:  next_s.pf1     = pwdata[7:0];
                OFS_PE1:  next_s.pe1     = pwdata[7:0];
                OFS_PP1:  next_s.pp1     = pwdata[7:0];
                OFS_PE2:  next_s.usb_en  = pwdata[BIT_USB];
                OFS_PP2:  next_s.usb_pri = pwdata[BIT_USB];
                OFS_CPRI: next_s.cpri    = pwdata[2:0];
                OFS_USBF: next_s.usbf    = pwdata[NUSB-1:0];
                OFS_USBE: next_s.usbe    = pwdata[NUSB-1:0];
                default:  next_s.ictl    = next_s.ictl;
            endcase
        end

        // Events win over a same-cycle software clear
        next_s.ictl[2] = next_s.ictl[2] | timer_zero_overflow_event;
        next_s.ictl[1] = next_s.ictl[1] | external_pin_zero_event;
        next_s.ictl[0] = next_s.ictl[0] | port_change_event;
        next_s.pf1     = next_s.pf1 | periph_event;
        next_s.usbf    = next_s.usbf | usb_event;

        case (s.state)
            ST_IDLE: begin
                if (req_hi) begin
                    next_s.state           = ST_WAIT;
                    next_s.icnt            = 2'd0;
                    next_s.vec_hi          = 1'b1;
                    next_s.ictl[BIT_GHIGH] = 1'b0;
                end else if (req_lo) begin
                    next_s.state          = ST_WAIT;
                    next_s.icnt           = 2'd0;
                    next_s.vec_hi         = 1'b0;
                    next_s.ictl[BIT_GLOW] = 1'b0;
                end else if (return_from_interrupt_instr) begin
                    if (s.svc_hi) begin
                        next_s.svc_hi          = 1'b0;
                        next_s.ictl[BIT_GHIGH] = 1'b1;
                    end else if (s.svc_lo) begin
                        next_s.svc_lo         = 1'b0;
                        next_s.ictl[BIT_GLOW] = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                // Fixed count of instruction ticks, independent of opcode length
                if (tick) begin
                    next_s.icnt = s.icnt + 2'd1;
                    if (s.icnt == 2'(LAT_INSTR - 1)) begin
                        next_s.state = ST_VECT;
                        next_s.push  = 1'b1;
                        next_s.load  = 1'b1;
                        next_s.vaddr = s.vec_hi ? VEC_HIGH : VEC_LOW;
                        if (s.vec_hi) begin
                            next_s.svc_hi = 1'b1;
                        end else begin
                            next_s.svc_lo = 1'b1;
                        end
                    end
                end
            end
            ST_VECT: begin
                next_s.state = ST_IDLE;
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s         <= '0;
            s.ictl    <= RST_REG8;
            s.pf1     <= RST_REG8;
            s.pe1     <= RST_REG8;
            s.pp1     <= RST_REG8;
            s.pen     <= 1'b0;
            s.state   <= ST_IDLE;
            s.vaddr   <= VEC_HIGH;
        end else begin
            s <= next_s;
        end
    end

    assign prdata       = s.rdata;
    assign pready       = s.rdy;
    assign pslverr      = s.err;
    assign stack_push   = s.push;
    assign pc_load      = s.load;
    assign vector_addr  = s.vaddr;
    assign service_high = s.svc_hi;
    assign service_low  = s.svc_lo;

    // ========================================================
    // Checks
    AST_VEC_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        pc_load |-> vector_addr == (s.vec_hi ? VEC_HIGH : VEC_LOW))
        else $error("vector address does not match level");

    AST_COMPAT_VEC: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && !s.pen && req_hi) |=> s.vec_hi)
        else $error("compatibility request not on high vector");

    AST_PREEMPT: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && s.pen && s.svc_lo && s.ictl[BIT_GHIGH] && |hi_act)
        |=> (s.state == ST_WAIT && s.vec_hi))
        else $error("high request did not preempt low routine");

    AST_NO_GLOBAL: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && !s.ictl[BIT_GHIGH]) |=> s.state != ST_WAIT)
        else $error("accepted with global enable clear");

    AST_ENTRY_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && req_hi) |=> !s.ictl[BIT_GHIGH])
        else $error("global enable not cleared on entry");

    AST_LOW_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && s.svc_hi) |=> !(s.state == ST_WAIT && !s.vec_hi))
        else $error("low request taken during high routine");

    AST_PUSH_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pc_load) |-> stack_push ##1 (!pc_load && !stack_push))
        else $error("push and load not paired one-cycle pulses");

    AST_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && !req_hi && !req_lo && s.svc_hi
         && return_from_interrupt_instr && !apb_wr)
        |=> (s.ictl[BIT_GHIGH] && !s.svc_hi))
        else $error("return did not restore high enable");

    AST_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && (req_hi || req_lo)) |-> ##[10:13] pc_load)
        else $error("vector latency out of range");

    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        external_pin_zero_event |=> s.ictl[1])
        else $error("event flag not set");

    AST_SRC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && ~|act) |=> s.state == ST_IDLE)
        else $error("disabled sources caused a vector");

    // Checks below, except AST_LOW_RETURN, use raw enables and flags, not the request terms they guard
    AST_LOW_VEC: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && s.pen && s.ictl[BIT_GHIGH] && s.ictl[BIT_GLOW]
         && !s.svc_hi && !s.svc_lo && |lo_act && ~|hi_act)
        |=> (s.state == ST_WAIT && !s.vec_hi))
        else $error("low request not on low vector");

    AST_LOW_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && s.pen && s.ictl[BIT_GHIGH] && s.ictl[BIT_GLOW]
         && !s.svc_hi && !s.svc_lo && |lo_act && ~|hi_act && !apb_wr)
        |=> (!s.ictl[BIT_GLOW] && s.ictl[BIT_GHIGH]))
        else $error("low entry did not clear only the low enable");

    AST_BOTH_LEVELS: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && s.pen && s.ictl[BIT_GHIGH] && s.ictl[BIT_GLOW]
         && !s.svc_hi && !s.svc_lo && |hi_act && |lo_act)
        |=> (s.state == ST_WAIT && s.vec_hi))
        else $error("simultaneous levels not taken high first");

    AST_USB_PRI: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && s.pen && s.usb_pri && s.usb_en && usb_device_level_flag
         && s.ictl[BIT_GHIGH]) |=> (s.state == ST_WAIT && s.vec_hi))
        else $error("usb priority bit not applied");

    AST_COMPAT_PER: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && !s.pen && s.ictl[BIT_GHIGH] && s.ictl[BIT_GLOW]
         && |act[NSRC-1:NCORE]) |=> (s.state == ST_WAIT && s.vec_hi))
        else $error("peripheral request not on single vector");

    AST_PERIPH_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && !s.pen && !s.ictl[BIT_GLOW] && ~|act[NCORE-1:0])
        |=> s.state == ST_IDLE)
        else $error("peripheral taken with group enable clear");

    AST_PUSH_VEC: assert property (@(posedge pclk) disable iff (!presetn)
        stack_push |-> (pc_load && (vector_addr == VEC_HIGH || vector_addr == VEC_LOW)))
        else $error("push without load of a vector address");

    AST_LOAD_SVC: assert property (@(posedge pclk) disable iff (!presetn)
        pc_load |-> (service_high || service_low))
        else $error("vector load without routine level");

    AST_LOW_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
        (s.state == ST_IDLE && !req_hi && !req_lo && !s.svc_hi && s.svc_lo
         && return_from_interrupt_instr && !apb_wr) |=> (s.ictl[BIT_GLOW] && !s.svc_lo))
        else $error("return did not restore low enable");

    AST_FLAG_TMR: assert property (@(posedge pclk) disable iff (!presetn)
        timer_zero_overflow_event |=> s.ictl[2])
        else $error("timer flag not set");

    AST_FLAG_PORT: assert property (@(posedge pclk) disable iff (!presetn)
        port_change_event |=> s.ictl[0])
        else $error("port change flag not set");

    AST_FLAG_PER: assert property (@(posedge pclk) disable iff (!presetn)
        (periph_event != 8'h00) |=> ((s.pf1 & $past(periph_event)) == $past(periph_event)))
        else $error("peripheral flag not set");

    AST_USB_MERGE: assert property (@(posedge pclk) disable iff (!presetn)
        (|(usb_event & s.usbe) && !apb_wr) |=> usb_device_level_flag)
        else $error("enabled usb event not merged into device flag");

endmodule : tlic_top

// File: rtl/tlic_pkg.sv
// Shared constants and types of the two-level interrupt controller
package tlic_pkg;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_ICTL  = 8'h00;
    localparam logic [7:0] OFS_RCS   = 8'h04;
    localparam logic [7:0] OFS_PF1   = 8'h08;
    localparam logic [7:0] OFS_PE1   = 8'h0C;
    localparam logic [7:0] OFS_PP1   = 8'h10;
    localparam logic [7:0] OFS_PF2   = 8'h14;
    localparam logic [7:0] OFS_PE2   = 8'h18;
    localparam logic [7:0] OFS_PP2   = 8'h1C;
    localparam logic [7:0] OFS_CPRI  = 8'h20;
    localparam logic [7:0] OFS_USBF  = 8'h24;
    localparam logic [7:0] OFS_USBE  = 8'h28;

    // ========================================================
    // Field positions
    localparam int BIT_GHIGH = 7;
    localparam int BIT_GLOW  = 6;
    localparam int BIT_PEN   = 7;
    localparam int BIT_USB   = 5;

    // ========================================================
    // Reset values
    localparam logic [7:0] RST_REG8 = 8'h00;

    // ========================================================
    // Vectors and timing
    localparam logic [20:0] VEC_HIGH      = 21'h0_0008;
    localparam logic [20:0] VEC_LOW       = 21'h0_0018;
    localparam int          CYC_PER_INSTR = 4;
    localparam int          LAT_INSTR     = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_VECT = 2'b11
    } tlic_state_t;

endpackage : tlic_pkg

// File: verif/tlic_core_model.sv
// Behavioural processor core: issues returns and watches vector entry
`timescale 1ns/1ps

module tlic_core_model #(
    parameter int RET_DLY = 3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic stack_push,
    input  wire logic pc_load,
    input  wire logic ret_req,
    output logic      return_from_interrupt_instr,
    output logic      push_ok
);
    int cnt;

    // ========================================================
    // Return comes some cycles after the request, as a slow core would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            return_from_interrupt_instr <= 1'b0;
            push_ok <= 1'b1;
        end else begin
            return_from_interrupt_instr <= 1'b0;
            if (ret_req) begin
                cnt <= RET_DLY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
                return_from_interrupt_instr <= (cnt == 1);
            end
            if (pc_load != stack_push) begin
                push_ok <= 1'b0;
            end
        end
    end
endmodule : tlic_core_model

// File: verif/tb.sv
// Self-checking bench of the two-level interrupt controller
`timescale 1ns/1ps

module tb;
    import tlic_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        ret_req = 0, ev_t = 0, ev_p = 0, ev_c = 0;
    logic [7:0]  paddr = 0, ev_per = 0, ev_usb = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic        pready, pslverr, err, stack_push, pc_load, svc_h, svc_l, rfi, push_ok;
    logic [20:0] vector_addr;
    int          n_mismatch = 0, checks = 0, lat, k;
    localparam logic [7:0] FL [5] = '{8'h02, 8'h04, 8'h01, 8'h00, 8'h00};

    always #25 pclk = ~pclk;

    tlic_top u_tlic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_zero_overflow_event(ev_t), .external_pin_zero_event(ev_p),
        .port_change_event(ev_c), .periph_event(ev_per), .usb_event(ev_usb),
        .return_from_interrupt_instr(rfi), .stack_push(stack_push), .pc_load(pc_load),
        .vector_addr(vector_addr), .service_high(svc_h), .service_low(svc_l));
    tlic_core_model u_tlic_core_model (.pclk(pclk), .presetn(presetn),
        .stack_push(stack_push), .pc_load(pc_load), .ret_req(ret_req),
        .return_from_interrupt_instr(rfi), .push_ok(push_ok));

    // ========================================================
    // Reporting
    task automatic final_report;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // ========================================================
    // Bus and event drivers; every control change is one whole APB write
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_mismatch++;
            final_report();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(q, {24'h00_0000, e});
    endtask : rdchk

    task automatic pulse(input int s);
        @(posedge pclk);
        case (s)
            0: ev_p <= 1'b1;
            1: ev_t <= 1'b1;
            2: ev_c <= 1'b1;
            3: ev_per <= 8'h01;
            default: ev_usb <= 8'h08;
        endcase
        @(posedge pclk);
        {ev_p, ev_t, ev_c} <= 3'b000;
        ev_per <= 8'h00;
        ev_usb <= 8'h00;
    endtask : pulse

    task automatic wait_vec(input logic [20:0] e);
        lat = 0;
        do begin
            @(posedge pclk);
            lat++;
        end while (pc_load !== 1'b1 && lat < 60);
        if (lat >= 60) begin
            n_mismatch++;
            final_report();
        end
        chk({11'h000, vector_addr}, {11'h000, e});
    endtask : wait_vec

    task automatic no_vec;
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (pc_load === 1'b1) break;
        end
        chk(i, 40);
    endtask : no_vec

    task automatic ret;
        int i;
        i = 0;
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
        do begin
            @(posedge pclk);
            i++;
        end while (rfi !== 1'b1 && i < 20);
        chk(i < 20, 1);
        if (i >= 20) begin
            final_report();
        end
        @(posedge pclk);
    endtask : ret

    // ========================================================
    // Scenarios
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({11'h000, vector_addr}, {11'h000, VEC_HIGH});
        rdchk(OFS_ICTL, 8'h00);
        rdchk(OFS_RCS, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        chk(err, 1);
        chk(q, 0);
        apb(1'b1, OFS_PF2, 8'hFF);
        rdchk(OFS_PF2, 8'h00);
        // Compatibility mode, every source class, priorities all low
        apb(1'b1, OFS_PE1, 8'h01);
        apb(1'b1, OFS_PE2, 8'h20);
        apb(1'b1, OFS_USBE, 8'h08);
        apb(1'b1, OFS_ICTL, 8'hF8);
        for (k = 0; k < 5; k++) begin
            pulse(k);
            wait_vec(VEC_HIGH);
            chk(lat >= 10 && lat <= 16, 1);
            chk(svc_h, 1);
            rdchk(OFS_ICTL, 8'h78 | FL[k]);
            if (k == 4) rdchk(OFS_PF2, 8'h20);
            apb(1'b1, OFS_ICTL, 8'h78);
            apb(1'b1, OFS_PF1, 8'h00);
            apb(1'b1, OFS_USBF, 8'h00);
            ret();
            rdchk(OFS_ICTL, 8'hF8);
            chk(svc_h, 0);
        end
        apb(1'b1, OFS_ICTL, 8'hB8);
        pulse(3);
        no_vec();
        apb(1'b1, OFS_ICTL, 8'hF8);
        wait_vec(VEC_HIGH);
        apb(1'b1, OFS_ICTL, 8'h78);
        apb(1'b1, OFS_PF1, 8'h00);
        ret();
        apb(1'b1, OFS_PE1, 8'h00);
        pulse(3);
        no_vec();
        rdchk(OFS_PF1, 8'h01);
        apb(1'b1, OFS_PF1, 8'h00);
        apb(1'b1, OFS_PE1, 8'h01);
        // Priority mode: low entry, high preemption, nested returns
        apb(1'b1, OFS_RCS, 8'h80);
        apb(1'b1, OFS_CPRI, 8'h02);
        apb(1'b1, OFS_PP2, 8'h20);
        rdchk(OFS_RCS, 8'h80);
        pulse(3);
        wait_vec(VEC_LOW);
        chk(svc_l, 1);
        rdchk(OFS_ICTL, 8'hB8);
        pulse(0);
        wait_vec(VEC_HIGH);
        rdchk(OFS_ICTL, 8'h3A);
        apb(1'b1, OFS_ICTL, 8'h38);
        ret();
        rdchk(OFS_ICTL, 8'hB8);
        chk({svc_h, svc_l}, 2'b01);
        apb(1'b1, OFS_PF1, 8'h00);
        ret();
        rdchk(OFS_ICTL, 8'hF8);
        // Both levels pending when the enables open together
        apb(1'b1, OFS_ICTL, 8'h38);
        pulse(0);
        pulse(3);
        rdchk(OFS_ICTL, 8'h3A);
        apb(1'b1, OFS_ICTL, 8'hFA);
        wait_vec(VEC_HIGH);
        no_vec();
        apb(1'b1, OFS_ICTL, 8'h78);
        ret();
        wait_vec(VEC_LOW);
        apb(1'b1, OFS_PF1, 8'h00);
        ret();
        pulse(4);
        wait_vec(VEC_HIGH);
        apb(1'b1, OFS_USBF, 8'h00);
        ret();
        rdchk(OFS_ICTL, 8'hF8);
        chk(push_ok, 1);
        final_report();
    end
endmodule : tb
